// File: hdl/dtc_mcyc.sv
// Machine-cycle strobe: one pulse every MCYC_CLKS processor clocks
module dtc_mcyc
    import dtc_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_srst,
    output logic      o_tick
);
    logic [3:0] div_q;    // Clock count within a machine cycle
    logic       tick_q;   // Registered strobe

    // Divide the processor clock by twelve
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            div_q  <= 4'h0;
            tick_q <= 1'b0;
        end else if (div_q == 4'(MCYC_CLKS - 1)) begin
            div_q  <= 4'h0;
            tick_q <= 1'b1;   // RULE2
        end else begin
            div_q  <= div_q + 4'h1;
            tick_q <= 1'b0;
        end
    end

    assign o_tick = tick_q;

    chk_tick_spacing: assert property (@(posedge i_clk) disable iff (i_srst) // RULE2
        tick_q |-> ##12 tick_q)
        else $error("machine cycle strobe not every twelve clocks");
endmodule : dtc_mcyc

// File: hdl/dtc_pin_sync.sv
// Pin synchroniser with agreement filter and machine-cycle fall detector
module dtc_pin_sync (
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_pin,
    input  wire logic i_tick,
    output logic      o_level,
    output logic      o_fall
);
    logic s1_q, s2_q, s3_q;   // Synchroniser chain, idle high
    logic lvl_q;              // Level accepted once stages two and three agree
    logic samp_q;             // Level sampled at the previous machine cycle
    logic fall_q;             // One-clock pulse per accepted falling edge

    // Three-stage capture; stage one feeds only stage two
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a change only when two stages agree
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            lvl_q <= 1'b1;
        end else if (s2_q == s3_q) begin
            lvl_q <= s3_q;
        end
    end

    // Sample once per machine cycle; a fall needs a high sample then a low one,
    // so recognition spans two machine cycles and caps the count rate
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            samp_q <= 1'b1;
            fall_q <= 1'b0;
        end else begin
            fall_q <= i_tick & samp_q & ~lvl_q;   // RULE4
            if (i_tick) begin
                samp_q <= lvl_q;
            end
        end
    end

    assign o_level = lvl_q;
    assign o_fall  = fall_q;

    chk_fall_one_clock: assert property (@(posedge i_clk) disable iff (i_srst) // RULE4
        fall_q |=> !fall_q)
        else $error("fall pulse longer than one clock");
endmodule : dtc_pin_sync

// File: hdl/dtc_pkg.sv
package dtc_pkg;
    // Register byte offsets on the APB slave
    localparam logic [7:0] OFF_MODE     = 8'h00;   // timer_mode_select
    localparam logic [7:0] OFF_CTRL     = 8'h04;   // timer_run_flag_control
    localparam logic [7:0] OFF_CNT0     = 8'h08;   // high_byte_first:low_byte_first
    localparam logic [7:0] OFF_CNT1     = 8'h0C;   // high_byte_second:low_byte_second
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;   // Sticky events, cleared on read
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;   // Interrupt enables

    // Mode register field positions (second unit high nibble, first unit low)
    localparam int MODE_GATE_SECOND = 7;
    localparam int MODE_SRC_SECOND  = 6;
    localparam int MODE_FLD_SECOND  = 4;           // Bits 5:4
    localparam int MODE_GATE_FIRST  = 3;
    localparam int MODE_SRC_FIRST   = 2;
    localparam int MODE_FLD_FIRST   = 0;           // Bits 1:0

    // Control register field positions
    localparam int CTRL_OVF_SECOND = 7;
    localparam int CTRL_RUN_SECOND = 6;
    localparam int CTRL_OVF_FIRST  = 5;
    localparam int CTRL_RUN_FIRST  = 4;

    // Interrupt status and mask bit positions
    localparam int IRQ_OVF_FIRST  = 0;
    localparam int IRQ_OVF_SECOND = 1;

    // Mode field encodings
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RLD8  = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // Reset values
    localparam logic [7:0]  RST_MODE = 8'h00;
    localparam logic [15:0] RST_CNT  = 16'h0000;
    localparam logic [1:0]  RST_IRQ  = 2'h0;

    // One machine cycle in processor clock periods
    localparam int MCYC_CLKS = 12;
endpackage : dtc_pkg

// File: hdl/dtc_timer.sv
// What this block does
// RULE1 - Two up-counters, each low and high byte
// RULE2 - Timer counts once per twelve clocks
// RULE3 - Counter counts falling edges of count input
// RULE4 - Edge recognition takes two machine cycles
// RULE5 - Count input stable one machine cycle
// RULE6 - Setting run bit starts counting
// RULE7 - Gate: count only while gate pin high
// RULE8 - Source bit picks counter or timer
// RULE9 - Two-bit field selects one of four modes
// RULE10 - 13-bit mode holds low byte top zero
// RULE11 - Auto-reload low byte from high byte
// RULE12 - Second unit in mode three halts
// RULE13 - First unit mode three: two 8-bit counters
// RULE14 - Split low byte: first controls, first flag
// RULE15 - Split high byte: second run, second flag
// RULE16 - Overflow flag set, software or service clears
// RULE17 - Clearing run bit stops counting
// RULE18 - No reload first with second 13/16-bit
// RULE19 - 13/16-bit overflow wraps and continues
//
// The APB interface to the registers and the placing of the registers were decided locally.
module dtc_timer
    import dtc_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Pins
    input  wire logic        i_count_input_first,
    input  wire logic        i_count_input_second,
    input  wire logic        i_gate_pin_first,
    input  wire logic        i_gate_pin_second,
    // Interrupt service acknowledge, one-clock pulses
    input  wire logic        i_svc_first,
    input  wire logic        i_svc_second,
    output logic             o_irq
);
    logic        tick;                     // Machine-cycle strobe
    logic        gate_lvl0, gate_lvl1;     // Filtered gate pin levels
    logic        fall0, fall1;             // Accepted count input falls
    logic [7:0]  mode_q;                   // timer_mode_select
    logic        run0_q, run1_q;           // Run bits
    logic        ovf0_q, ovf1_q;           // Overflow flags
    logic [7:0]  tl0_q, th0_q, tl1_q, th1_q; // Count bytes
    logic [1:0]  stat_q, mask_q;           // Interrupt status and mask
    logic        rdy_q, err_q;             // APB answer
    logic [31:0] rdata_q;                  // APB read data
    logic        acc, take, wr, rd;        // APB phase decode
    logic        wr_cnt0, wr_cnt1, wr_ctrl;
    logic [1:0]  md0, md1;                 // Mode fields
    logic        inc0, inc1, inc0h;        // Count enables
    logic [16:0] step0, step1;             // {overflow, high, low} after one count
    logic        ev_ovf0, ev_ovf1;         // Overflow events
    logic [31:0] rdata_d;                  // Read mux
    logic        hit;                      // Mapped address

    // One count step in the given mode; returns {overflow, high byte, low byte}
    function automatic logic [16:0] cnt_step(input logic [1:0] mode,
                                             input logic [7:0] tl,
                                             input logic [7:0] th);
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0]  c8;
        c13 = {1'b0, th, tl[4:0]} + 14'h0001;
        c16 = {1'b0, th, tl} + 17'h0_0001;
        c8  = {1'b0, tl} + 9'h001;
        case (mode)
            MODE_13BIT: cnt_step = {c13[13], c13[12:5], 3'b000, c13[4:0]}; // RULE10
            MODE_16BIT: cnt_step = c16;                                    // RULE19
            MODE_RLD8:  cnt_step = {c8[8], th, c8[8] ? th : c8[7:0]};      // RULE11
            default:    cnt_step = {c8[8], th, c8[7:0]};                   // RULE13
        endcase
    endfunction : cnt_step

    // Machine-cycle time base
    dtc_mcyc u_mcyc (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .o_tick (tick)
    );

    // Count and gate pins all arrive from outside the clock domain
    dtc_pin_sync u_cnt0 (
        .i_clk (i_clk), .i_srst (i_srst), .i_pin (i_count_input_first),
        .i_tick (tick), .o_level (), .o_fall (fall0)
    );
    dtc_pin_sync u_cnt1 (
        .i_clk (i_clk), .i_srst (i_srst), .i_pin (i_count_input_second),
        .i_tick (tick), .o_level (), .o_fall (fall1)
    );
    dtc_pin_sync u_gate0 (
        .i_clk (i_clk), .i_srst (i_srst), .i_pin (i_gate_pin_first),
        .i_tick (tick), .o_level (gate_lvl0), .o_fall ()
    );
    dtc_pin_sync u_gate1 (
        .i_clk (i_clk), .i_srst (i_srst), .i_pin (i_gate_pin_second),
        .i_tick (tick), .o_level (gate_lvl1), .o_fall ()
    );

    // APB decode: one wait state so read data comes from a flop
    assign acc     = i_psel & i_penable;
    assign take    = acc & rdy_q;
    assign wr      = take & i_pwrite;
    assign rd      = take & ~i_pwrite;
    assign wr_cnt0 = wr & (i_paddr == OFF_CNT0);
    assign wr_cnt1 = wr & (i_paddr == OFF_CNT1);
    assign wr_ctrl = wr & (i_paddr == OFF_CTRL);

    assign md0 = mode_q[MODE_FLD_FIRST +: 2];
    assign md1 = mode_q[MODE_FLD_SECOND +: 2];

    // Count enables: run bit, optional gate, then tick or pin fall
    assign inc0 = run0_q                                                       // RULE6 RULE17
                & (~mode_q[MODE_GATE_FIRST] | gate_lvl0)                       // RULE7 RULE14
                & (mode_q[MODE_SRC_FIRST] ? fall0 : tick);                     // RULE8 RULE3
    // Split high byte of the first unit is a timer on the second run bit
    assign inc0h = (md0 == MODE_SPLIT) & run1_q & tick;                        // RULE15
    assign inc1 = run1_q & (md1 != MODE_SPLIT)                                 // RULE12
                & (~mode_q[MODE_GATE_SECOND] | gate_lvl1)                      // RULE7
                & (mode_q[MODE_SRC_SECOND] ? fall1 : tick);                    // RULE8 RULE3

    assign step0 = cnt_step(md0, tl0_q, th0_q);                                // RULE9
    assign step1 = cnt_step(md1, tl1_q, th1_q);                                // RULE9

    // In split mode the second flag belongs to the first unit's high byte
    assign ev_ovf0 = inc0 & step0[16] & ~wr_cnt0;                              // RULE14
    assign ev_ovf1 = (md0 == MODE_SPLIT) ? (inc0h & (th0_q == 8'hFF) & ~wr_cnt0) // RULE15
                                         : (inc1 & step1[16] & ~wr_cnt1);

    // Mode register; software keeps the illegal pairing out
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mode_q <= RST_MODE;
        end else if (wr & (i_paddr == OFF_MODE)) begin
            mode_q <= i_pwdata[7:0];                                           // RULE18
        end
    end

    // Run bits follow software writes only
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            run0_q <= 1'b0;
            run1_q <= 1'b0;
        end else if (wr_ctrl) begin
            run0_q <= i_pwdata[CTRL_RUN_FIRST];                                // RULE6
            run1_q <= i_pwdata[CTRL_RUN_SECOND];                               // RULE17
        end
    end

    // Overflow flags: a hardware set wins over a write or service clear
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ovf0_q <= 1'b0;
            ovf1_q <= 1'b0;
        end else begin
            if (ev_ovf0) begin
                ovf0_q <= 1'b1;                                                // RULE16
            end else if (i_svc_first) begin
                ovf0_q <= 1'b0;
            end else if (wr_ctrl) begin
                ovf0_q <= i_pwdata[CTRL_OVF_FIRST];
            end
            if (ev_ovf1) begin
                ovf1_q <= 1'b1;                                                // RULE16
            end else if (i_svc_second) begin
                ovf1_q <= 1'b0;
            end else if (wr_ctrl) begin
                ovf1_q <= i_pwdata[CTRL_OVF_SECOND];
            end
        end
    end

    // First unit count; a software load beats a count in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            {th0_q, tl0_q} <= RST_CNT;
        end else if (wr_cnt0) begin
            {th0_q, tl0_q} <= i_pwdata[15:0];
        end else begin
            if (inc0) begin
                tl0_q <= step0[7:0];                                           // RULE1 RULE14
                if (md0 != MODE_SPLIT) begin
                    th0_q <= step0[15:8];                                      // RULE19
                end
            end
            if (inc0h) begin
                th0_q <= th0_q + 8'h01;                                        // RULE13
            end
        end
    end

    // Second unit count; mode three leaves it frozen
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            {th1_q, tl1_q} <= RST_CNT;
        end else if (wr_cnt1) begin
            {th1_q, tl1_q} <= i_pwdata[15:0];
        end else if (inc1) begin
            {th1_q, tl1_q} <= step1[15:0];                                     // RULE1 RULE12
        end
    end

    // Interrupt mask
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mask_q <= RST_IRQ;
        end else if (wr & (i_paddr == OFF_IRQ_MASK)) begin
            mask_q <= i_pwdata[1:0];
        end
    end

    // Sticky status, cleared by the read that returns it; new events survive
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            stat_q <= RST_IRQ;
        end else begin
            // Clear only what the read captured; a set after capture is not lost
            stat_q <= (stat_q & ~((rd & (i_paddr == OFF_IRQ_STAT)) ? rdata_q[1:0] : 2'b00))
                    | {ev_ovf1, ev_ovf0};
        end
    end

    assign o_irq = |(stat_q & mask_q);

    // Read mux; unmapped addresses read zero and flag an error
    always_comb begin
        rdata_d = 32'h0000_0000;
        hit     = 1'b1;
        case (i_paddr)
            OFF_MODE:     rdata_d[7:0] = mode_q;
            OFF_CTRL:     rdata_d[7:0] = {ovf1_q, run1_q, ovf0_q, run0_q, 4'h0};
            OFF_CNT0:     rdata_d[15:0] = {th0_q, tl0_q};
            OFF_CNT1:     rdata_d[15:0] = {th1_q, tl1_q};
            OFF_IRQ_STAT: rdata_d[1:0] = stat_q;
            OFF_IRQ_MASK: rdata_d[1:0] = mask_q;
            default:      hit = 1'b0;
        endcase
    end

    // Answer on the second access cycle with registered data
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdy_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            rdy_q <= acc & ~rdy_q;
            if (acc & ~rdy_q) begin
                err_q   <= ~hit;
                rdata_q <= i_pwrite ? 32'h0000_0000 : rdata_d;
            end else begin
                err_q <= 1'b0;
            end
        end
    end

    assign o_pready  = rdy_q;
    assign o_pslverr = err_q;
    assign o_prdata  = rdata_q;

    // Assertions
    chk_stop_holds: assert property (@(posedge i_clk) disable iff (i_srst) // RULE17
        (!run0_q && !wr_cnt0 && md0 != MODE_SPLIT) |=> $stable({th0_q, tl0_q}))
        else $error("first unit moved while stopped");
    chk_gate_blocks: assert property (@(posedge i_clk) disable iff (i_srst) // RULE7
        (mode_q[MODE_GATE_SECOND] && !gate_lvl1 && !wr_cnt1) |=> $stable({th1_q, tl1_q}))
        else $error("second unit moved with gate low");
    chk_halt_second: assert property (@(posedge i_clk) disable iff (i_srst) // RULE12
        (md1 == MODE_SPLIT && !wr_cnt1) |=> $stable({th1_q, tl1_q}))
        else $error("second unit moved in mode three");
    chk_mode13_top: assert property (@(posedge i_clk) disable iff (i_srst) // RULE10
        (inc1 && md1 == MODE_13BIT && !wr_cnt1) |=> tl1_q[7:5] == 3'b000)
        else $error("13-bit low byte top bits not zero");
    chk_reload_low: assert property (@(posedge i_clk) disable iff (i_srst) // RULE11
        (inc0 && md0 == MODE_RLD8 && tl0_q == 8'hFF && !wr_cnt0)
        |=> tl0_q == $past(th0_q) && ovf0_q)
        else $error("auto-reload failed");
    chk_wrap16: assert property (@(posedge i_clk) disable iff (i_srst) // RULE19
        (inc0 && md0 == MODE_16BIT && {th0_q, tl0_q} == 16'hFFFF && !wr_cnt0)
        |=> {th0_q, tl0_q} == 16'h0000 && ovf0_q)
        else $error("16-bit wrap or flag wrong");
    chk_split_high: assert property (@(posedge i_clk) disable iff (i_srst) // RULE15
        (inc0h && th0_q == 8'hFF && !wr_cnt0) |=> th0_q == 8'h00 && ovf1_q)
        else $error("split high byte overflow wrong");
    // Split low byte wrap: the step that takes it past all ones
    sequence seq_split_low_wrap;
        inc0 && md0 == MODE_SPLIT && tl0_q == 8'hFF && !wr_cnt0;
    endsequence
    chk_split_low: assert property (@(posedge i_clk) disable iff (i_srst) // RULE14
        seq_split_low_wrap |=> tl0_q == 8'h00 && ovf0_q)
        else $error("split low byte overflow wrong");
    chk_timer_rate: assert property (@(posedge i_clk) disable iff (i_srst) // RULE2
        (run0_q && md0 == MODE_16BIT && !mode_q[MODE_SRC_FIRST]
         && !mode_q[MODE_GATE_FIRST] && inc0) |=> !inc0 [*8])
        else $error("timer counted faster than one per machine cycle");
    chk_counter_fall: assert property (@(posedge i_clk) disable iff (i_srst) // RULE3
        (mode_q[MODE_SRC_FIRST] && !fall0) |-> !inc0)
        else $error("counter counted without a fall");
    chk_irq_level: assert property (@(posedge i_clk) disable iff (i_srst) // RULE16
        ev_ovf0 |=> stat_q[IRQ_OVF_FIRST] && (o_irq == mask_q[IRQ_OVF_FIRST] || stat_q[1]))
        else $error("overflow did not reach status");
endmodule : dtc_timer

// File: sim/dtc_pin_model.sv
// Far side of the pins: count sources and gate levels
module dtc_pin_model
    import dtc_pkg::*;
(
    input  wire logic i_clk,
    output logic      o_count_first,
    output logic      o_count_second,
    output logic      o_gate_first,
    output logic      o_gate_second
);
    timeunit 1ns;
    timeprecision 1ns;

    // Count lines idle high so the first fall is a real edge
    initial begin
        o_count_first  = 1'b1;
        o_count_second = 1'b1;
        o_gate_first   = 1'b0;
        o_gate_second  = 1'b0;
    end

    // Each level lasts two machine cycles, twice the shortest the block accepts
    task automatic pulse(input int unit, input int n);
        repeat (n) begin
            repeat (2 * MCYC_CLKS) @(posedge i_clk);
            if (unit == 0) o_count_first <= 1'b0;
            else o_count_second <= 1'b0;
            repeat (2 * MCYC_CLKS) @(posedge i_clk);
            if (unit == 0) o_count_first <= 1'b1;
            else o_count_second <= 1'b1;
        end
    endtask : pulse

    // Gate level changes after an edge, like every other input
    task automatic set_gate(input int unit, input logic lvl);
        @(posedge i_clk);
        if (unit == 0) o_gate_first <= lvl;
        else o_gate_second <= lvl;
    endtask : set_gate
endmodule : dtc_pin_model

// File: sim/dtc_timer_bench.sv
// Self-checking bench: APB register traffic plus pin stimulus
module dtc_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import dtc_pkg::*;

    logic        i_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] o_prdata;
    logic        o_pready, o_pslverr, o_irq;
    logic        cnt_a, cnt_b, gate_a, gate_b;
    logic        svc_a = 1'b0, svc_b = 1'b0;
    logic [31:0] v, w;       // Read-back scratch
    logic        last_err;   // Error flag of the last transfer
    int          err_count = 0;
    int          n_tests = 0;

    // 10 MHz processor clock
    always #50 i_clk = ~i_clk;

    dtc_timer u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_count_input_first(cnt_a),
        .i_count_input_second(cnt_b), .i_gate_pin_first(gate_a), .i_gate_pin_second(gate_b),
        .i_svc_first(svc_a), .i_svc_second(svc_b), .o_irq(o_irq));

    dtc_pin_model u_pins (.i_clk(i_clk), .o_count_first(cnt_a), .o_count_second(cnt_b),
        .o_gate_first(gate_a), .o_gate_second(gate_b));

    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int k;
        @(posedge i_clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 1'b0;
        @(posedge i_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge i_clk);
            if (o_pready === 1'b1) break;
        end
        if (k == 20) begin
            chk("pready timeout", 1, 0);
            results();
        end
        rd = o_prdata;
        last_err = o_pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        apb(1'b1, a, d, dummy);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        apb(1'b0, a, 32'h0000_0000, d);
    endtask : rd

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(nm, exp, d);
    endtask : rdchk

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick

    // Service acknowledge, one clock wide
    task automatic svc(input int unit);
        @(posedge i_clk);
        if (unit == 0) svc_a <= 1'b1; else svc_b <= 1'b1;
        @(posedge i_clk);
        svc_a <= 1'b0; svc_b <= 1'b0;
    endtask : svc

    initial begin
        tick(8);
        i_srst <= 1'b0;
        // Reset values, unmapped access, read/write mode register
        rdchk("mode rst", OFF_MODE, 32'h0000_0000);
        rdchk("ctrl rst", OFF_CTRL, 32'h0000_0000);
        rdchk("cnt0 rst", OFF_CNT0, 32'h0000_0000);
        rdchk("cnt1 rst", OFF_CNT1, 32'h0000_0000);
        rdchk("stat rst", OFF_IRQ_STAT, 32'h0000_0000);
        rdchk("unmapped", 8'h18, 32'h0000_0000);
        chk("slverr", 1, last_err);
        wr(OFF_MODE, 32'h0000_00A5);
        rdchk("mode rw", OFF_MODE, 32'h0000_00A5);
        $display("test registers done");

        // Timer rate: 124 clocks of run give 10 or 11 machine cycles
        wr(OFF_MODE, 32'h0000_0001);
        wr(OFF_CTRL, 32'h0000_0010);
        tick(120);
        wr(OFF_CTRL, 32'h0000_0000);
        rd(OFF_CNT0, v);
        chk("rate", 1, (v >= 10 && v <= 11));
        tick(60);
        rdchk("stopped", OFF_CNT0, v);
        $display("test timer rate done");

        // 16-bit wrap, overflow flag, masked and unmasked interrupt
        wr(OFF_IRQ_MASK, 32'h0000_0000);
        wr(OFF_CNT0, 32'h0000_FFFF);
        wr(OFF_CTRL, 32'h0000_0010);
        tick(40);
        chk("irq masked", 0, o_irq);
        rd(OFF_CNT0, v);
        chk("wrap", 1, (v <= 32'h0000_0006));
        rdchk("ovf flag", OFF_CTRL, 32'h0000_0030);
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        tick(1);
        chk("irq on", 1, o_irq);
        rdchk("stat set", OFF_IRQ_STAT, 32'h0000_0001);
        tick(1);
        chk("irq off", 0, o_irq);
        rdchk("stat clr", OFF_IRQ_STAT, 32'h0000_0000);
        $display("test overflow done");

        // Auto-reload, both units in reload mode as pairing allows
        wr(OFF_CTRL, 32'h0000_0000);
        wr(OFF_MODE, 32'h0000_0022);
        wr(OFF_CNT0, 32'h0000_C8FE);
        wr(OFF_CTRL, 32'h0000_0010);
        tick(60);
        rdchk("reload flag", OFF_CTRL, 32'h0000_0030);
        wr(OFF_CTRL, 32'h0000_0020);
        rd(OFF_CNT0, v);
        chk("reload hi", 32'h0000_00C8, v[15:8]);
        chk("reload lo", 1, (v[7:0] >= 8'hC8));
        svc(0);
        rdchk("svc first", OFF_CTRL, 32'h0000_0000);
        $display("test reload done");

        // 13-bit second unit: low byte top bits stay zero across wrap
        wr(OFF_MODE, 32'h0000_0000);
        wr(OFF_CNT1, 32'h0000_FFFD);
        wr(OFF_CTRL, 32'h0000_0040);
        tick(60);
        rdchk("13bit ovf", OFF_CTRL, 32'h0000_00C0);
        wr(OFF_CTRL, 32'h0000_0080);
        rd(OFF_CNT1, v);
        chk("13bit", 32'h0000_0000, v & 32'hFFFF_FFE0);
        svc(1);
        rdchk("svc second", OFF_CTRL, 32'h0000_0000);
        $display("test 13bit done");

        // Counter mode with gate, both units through one loop
        for (int u = 0; u < 2; u++) begin
            wr(OFF_MODE, (u == 0) ? 32'h0000_000D : 32'h0000_00D0);
            wr((u == 0) ? OFF_CNT0 : OFF_CNT1, 32'h0000_0000);
            wr(OFF_CTRL, (u == 0) ? 32'h0000_0010 : 32'h0000_0040);
            u_pins.pulse(u, 2);
            tick(40);
            rdchk("gate low", (u == 0) ? OFF_CNT0 : OFF_CNT1, 0);
            u_pins.set_gate(u, 1'b1);
            tick(60);
            rdchk("no edges", (u == 0) ? OFF_CNT0 : OFF_CNT1, 0);
            u_pins.pulse(u, 3);
            tick(40);
            rdchk("edges", (u == 0) ? OFF_CNT0 : OFF_CNT1, 3);
            wr(OFF_CTRL, 32'h0000_0000);
            u_pins.set_gate(u, 1'b0);
        end
        $display("test counter done");

        // Split mode: low byte on first controls, high byte on second run
        wr(OFF_CNT1, 32'h0000_1234);
        wr(OFF_MODE, 32'h0000_0033);
        wr(OFF_CNT0, 32'h0000_FEFE);
        wr(OFF_CTRL, 32'h0000_0010);
        tick(60);
        rdchk("split lo flag", OFF_CTRL, 32'h0000_0030);
        rd(OFF_CNT0, v);
        chk("split hi idle", 32'h0000_00FE, v[15:8]);
        wr(OFF_CTRL, 32'h0000_0040);
        rd(OFF_CNT0, v);
        tick(60);
        rdchk("split hi flag", OFF_CTRL, 32'h0000_00C0);
        rd(OFF_CNT0, w);
        chk("split lo held", v[7:0], w[7:0]);
        rdchk("second frozen", OFF_CNT1, 32'h0000_1234);
        wr(OFF_CTRL, 32'h0000_0000);
        $display("test split done");
        results();
    end
endmodule : dtc_timer_bench
